// ==== rtl/acd_pkg.sv ====
/*
 * Shared constants and types for the channel configuration and decimation block.
 * Assumes a single master clock and a simple synchronous register port.
 */
package acd_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CHAN     = 8;
	localparam int ADDR_W       = 4;
	localparam int DATA_W       = 32;
	localparam int SAMPLE_W     = 24;
	localparam int ACC_W        = 15;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_CLOCK   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_GAIN    = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CHCFG0  = 4'h8;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CLK_OSR_LSB  = 2;
	localparam int CLK_PWR_LSB  = 0;
	localparam int GAIN_FLD_W   = 4;
	localparam logic [2:0]  OSR_RESET  = 3'h3;
	localparam logic [1:0]  PWR_RESET  = 2'h2;
	localparam logic [2:0]  GAIN_BUF_MIN = 3'h3;
	localparam logic [13:0] OSR_BASE   = 14'h0080;

	// ****************************************
	// Reference settling time
	// ****************************************
	localparam int REF_SETTLE_NS = 100000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ACD_SEL_PINS = 4'h1,
		ACD_SEL_GND  = 4'h2,
		ACD_SEL_TSTP = 4'h4,
		ACD_SEL_TSTN = 4'h8
	} acd_sel_e;

	typedef enum logic [1:0] {
		ACD_PWR_VLP = 2'h0,
		ACD_PWR_LP  = 2'h1,
		ACD_PWR_HR  = 2'h2
	} acd_pwr_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} acd_req_s;

	typedef struct packed {
		logic                valid;
		logic [2:0]          chan;
		logic [SAMPLE_W-1:0] data;
	} acd_sample_s;

	function automatic logic [2:0] acd_gain_clip(input logic [3:0] fld);
		acd_gain_clip = fld[3] ? 3'h7 : fld[2:0];
	endfunction

endpackage

// ==== rtl/acd_mod_clk.sv ====
/*
 * Divide-by-two enable for the modulator rate.
 * Assumes CLK is the master clock.
 */
`timescale 1ns/1ps
module acd_mod_clk (
	input  wire logic CLK,
	input  wire logic RESET_N,
	output logic      mod_en
);
	import acd_pkg::*;

	logic ph_q;
	logic ph_d;

	always_comb begin
		ph_d = ~ph_q;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ph_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
		end
	end

	assign mod_en = ph_q; // [RQ11]
endmodule

// ==== rtl/acd_decim.sv ====
/*
 * One channel's sinc1 decimator: counts ones of the modulator stream over one ratio window.
 * Assumes mod_en is a one-cycle pulse at the modulator rate.
 */
`timescale 1ns/1ps
module acd_decim #(
	parameter int W = acd_pkg::ACC_W
) (
	input  wire logic             CLK,
	input  wire logic             RESET_N,
	input  wire logic             mod_en,
	input  wire logic             bit_in,
	input  wire logic             dump,
	output logic [W-1:0]          sum
);
	import acd_pkg::*;

	logic [W-1:0] acc_q;
	logic [W-1:0] acc_d;
	logic [W-1:0] sum_q;
	logic [W-1:0] sum_d;

	// ****************************************
	// Boxcar average
	// ****************************************
	always_comb begin
		acc_d = acc_q;
		sum_d = sum_q;
		if (mod_en) begin
			if (dump) begin
				sum_d = acc_q + W'(bit_in); // [RQ13]
				acc_d = '0;
			end else begin
				acc_d = acc_q + W'(bit_in);
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			acc_q <= '0;
			sum_q <= '0;
		end else begin
			acc_q <= acc_d;
			sum_q <= sum_d;
		end
	end

	assign sum = sum_q;
endmodule

// ==== rtl/acd_top.sv ====
/*
 * Channel configuration and decimation control for an eight-channel converter.
 * Assumes synchronous register port, modulator bits from the analog side, CLK as master clock.
 *
// Notes on behaviour
// [RQ1] Each channel has a two-bit input selector choosing pins, ground or test signals.
// [RQ2] Selector codes: 0 pins, 1 ground, 2 positive test, 3 negative test.
// [RQ3] Gain per channel is one of 1,2,4,8,16,32,64,128.
// [RQ4] All channel gains live as separate fields in one gain register.
// [RQ5] Full-scale range is reference over gain; output scale follows gain.
// [RQ6] Precharge buffer on when gain is 8 or more.
// [RQ7] No conversion data output until the reference has settled.
// [RQ8] Host supplies master clock and reads data synchronous to it.
// [RQ9] Two-bit power field selects high-resolution, low-power or very-low-power.
// [RQ10] Host supplies clock matched to power mode: 8.192, 4.096, 2.048 MHz.
// [RQ11] Modulator clock is half the master clock.
// [RQ12] Each modulator gives a one-bit stream at modulator rate to its filter.
// [RQ13] Sinc-type filter averages the stream, one sample per ratio modulator clocks.
// [RQ14] Three-bit ratio field selects 128 doubling to 16384.
// [RQ15] Output data rate equals modulator rate over ratio.
// [RQ16] Ratio codes 0..7 map to 128..16384 ascending.
 */
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module acd_top #(
	parameter int REF_SETTLE = acd_pkg::REF_SETTLE_CYC
) (
	input  wire logic                            CLK,
	input  wire logic                            RESET_N,
	input  wire logic [acd_pkg::ADDR_W-1:0]      ADDR,
	input  wire logic [acd_pkg::DATA_W-1:0]      WDATA,
	input  wire logic                            WR,
	input  wire logic                            RD,
	output logic      [acd_pkg::DATA_W-1:0]      RDATA,
	input  wire logic [acd_pkg::NUM_CHAN-1:0]    MOD_BITS,
	output logic [4*acd_pkg::NUM_CHAN-1:0]       CHAN_INPUT_SELECT,
	output logic [3*acd_pkg::NUM_CHAN-1:0]       CHAN_GAIN,
	output logic [acd_pkg::NUM_CHAN-1:0]         PRECHARGE_EN,
	output logic [1:0]                           POWER_MODE,
	output logic                                 MOD_CLK_EN,
	output logic                                 SAMPLE_VALID,
	output logic [2:0]                           SAMPLE_CHAN,
	output logic [acd_pkg::SAMPLE_W-1:0]         SAMPLE_DATA
);
	import acd_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [1:0]              mux_q [NUM_CHAN];
	logic [1:0]              mux_d [NUM_CHAN];
	logic [2:0]              gain_q [NUM_CHAN];
	logic [2:0]              gain_d [NUM_CHAN];
	logic [2:0]              osr_q, osr_d;
	logic [1:0]              pwr_q, pwr_d;
	logic [DATA_W-1:0]       rdata_q, rdata_d;
	logic [31:0]             settle_q, settle_d;
	logic                    ready_q, ready_d;
	logic [13:0]             win_q, win_d;
	logic [14:0]             osr_n;
	logic                    dump;
	logic                    mod_en;
	logic                    mod_en_q;
	logic [ACC_W-1:0]        sums [NUM_CHAN];
	logic [NUM_CHAN-1:0]     bits_in;
	logic [NUM_CHAN-1:0]     test_pat_q, test_pat_d;
	acd_sample_s             out_q, out_d;
	logic [2:0]              emit_q, emit_d;
	logic                    emitting_q, emitting_d;
	logic [4*NUM_CHAN-1:0]   sel_q, sel_d;
	logic [3*NUM_CHAN-1:0]   gout_q, gout_d;
	logic [NUM_CHAN-1:0]     pre_q, pre_d;

	// ****************************************
	// Selector decode
	// ****************************************
	function automatic acd_sel_e sel_decode(input logic [1:0] code);
		unique case (code)
			2'h0: sel_decode = ACD_SEL_PINS; // [RQ2]
			2'h1: sel_decode = ACD_SEL_GND;
			2'h2: sel_decode = ACD_SEL_TSTP;
			2'h3: sel_decode = ACD_SEL_TSTN;
		endcase
	endfunction

	// The modulator rate is an enable, not a derived clock, so the block keeps one clock domain.
	acd_mod_clk u_mod_clk (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.mod_en  (mod_en)
	);

	// ****************************************
	// Modulator stream per channel
	// ****************************************
	// Ground reads as alternating bits (mid-scale); test signals as fixed density.
	always_comb begin
		test_pat_d = mod_en ? ~test_pat_q : test_pat_q;
		for (int i = 0; i < NUM_CHAN; i++) begin
			unique case (mux_q[i])
				2'h0: bits_in[i] = MOD_BITS[i]; // [RQ1]
				2'h1: bits_in[i] = test_pat_q[i];
				2'h2: bits_in[i] = 1'b1;
				2'h3: bits_in[i] = 1'b0;
			endcase
		end
	end

	// ****************************************
	// Decimation window
	// ****************************************
	assign osr_n = {1'b0, OSR_BASE} << osr_q; // [RQ14] [RQ16]
	// Greater-or-equal ends the window at once when the ratio is lowered in mid-window.
	assign dump  = ({1'b0, win_q} >= osr_n - 15'h0001);

	always_comb begin
		win_d = win_q;
		if (mod_en) begin
			win_d = dump ? 14'h0000 : win_q + 14'h0001; // [RQ15]
		end
	end

	// ****************************************
	// Per-channel decimators
	// ****************************************
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_ch
		acd_decim u_decim (
			.CLK     (CLK),
			.RESET_N (RESET_N),
			.mod_en  (mod_en),
			.bit_in  (bits_in[g]), // [RQ12]
			.dump    (dump),
			.sum     (sums[g])
		);
	end

	// ****************************************
	// Reference settling
	// ****************************************
	always_comb begin
		settle_d = settle_q;
		ready_d  = ready_q;
		// The count stops once ready is set, so it can never wrap and clear the flag.
		if (!ready_q) begin
			if (settle_q >= 32'(REF_SETTLE - 1)) begin
				ready_d = 1'b1;
			end else begin
				settle_d = settle_q + 32'h1;
			end
		end
	end

	// ****************************************
	// Sample output: one channel per cycle after each window
	// ****************************************
	always_comb begin
		emit_d      = emit_q;
		emitting_d  = emitting_q;
		out_d       = '0;
		// A burst lasts eight cycles, far less than the shortest window, so bursts never overlap.
		if (mod_en && dump && ready_q) begin // [RQ7]
			emitting_d = 1'b1;
			emit_d     = 3'h0;
		end
		if (emitting_q) begin
			out_d.valid = 1'b1;
			out_d.chan  = emit_q;
			// Count scaled so a full window of ones reads 0x10000 at every ratio; gain only changes the input-referred scale.
			out_d.data  = SAMPLE_W'({sums[emit_q], {(SAMPLE_W-ACC_W){1'b0}}} >> osr_q); // [RQ5]
			emit_d      = emit_q + 3'h1;
			if (emit_q == 3'h7) begin
				emitting_d = 1'b0;
			end
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	always_comb begin
		osr_d   = osr_q;
		pwr_d   = pwr_q;
		rdata_d = '0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			mux_d[i]  = mux_q[i];
			gain_d[i] = gain_q[i];
		end
		if (WR) begin
			if (ADDR == OFS_CLOCK) begin
				osr_d = WDATA[CLK_OSR_LSB +: 3];
				pwr_d = (WDATA[CLK_PWR_LSB +: 2] == 2'h3) ? ACD_PWR_HR : WDATA[CLK_PWR_LSB +: 2]; // [RQ9]
			end
			if (ADDR == OFS_GAIN) begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					gain_d[i] = acd_gain_clip(WDATA[i*GAIN_FLD_W +: GAIN_FLD_W]); // [RQ3] [RQ4]
				end
			end
			// Channel configuration answers at OFS_CHCFG0 and above; the low three address bits pick the channel.
			if (ADDR >= OFS_CHCFG0) begin
				mux_d[ADDR[2:0]] = WDATA[1:0];
			end
		end
		if (RD) begin
			if (ADDR == OFS_CLOCK) begin
				rdata_d = DATA_W'({osr_q, pwr_q});
			end else if (ADDR == OFS_GAIN) begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					rdata_d[i*GAIN_FLD_W +: GAIN_FLD_W] = {1'b0, gain_q[i]};
				end
			end else if (ADDR == OFS_STATUS) begin
				rdata_d = DATA_W'(ready_q);
			end else if (ADDR >= OFS_CHCFG0) begin
				rdata_d = DATA_W'(mux_q[ADDR[2:0]]);
			end
		end
	end

	// ****************************************
	// Pin-side outputs
	// ****************************************
	// Pins are registered so that every output comes straight from a flip-flop.
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			sel_d[i*4 +: 4]  = sel_decode(mux_q[i]);
			gout_d[i*3 +: 3] = gain_q[i];
			pre_d[i]         = (gain_q[i] >= GAIN_BUF_MIN); // [RQ6]
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	// Selector and gain changes reach the pins one cycle after the register itself; POWER_MODE comes straight from pwr_q.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				mux_q[i]  <= 2'h0;
				gain_q[i] <= 3'h0;
			end
			osr_q   <= OSR_RESET;
			pwr_q   <= PWR_RESET;
			rdata_q <= '0;
		end else begin
			mux_q   <= mux_d;
			gain_q  <= gain_d;
			osr_q   <= osr_d;
			pwr_q   <= pwr_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			win_q      <= '0;
			test_pat_q <= 8'h55;
		end else begin
			win_q      <= win_d;
			test_pat_q <= test_pat_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			settle_q <= '0;
			ready_q  <= 1'b0;
		end else begin
			settle_q <= settle_d;
			ready_q  <= ready_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			out_q      <= '0;
			emit_q     <= 3'h0;
			emitting_q <= 1'b0;
		end else begin
			out_q      <= out_d;
			emit_q     <= emit_d;
			emitting_q <= emitting_d;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sel_q    <= {NUM_CHAN{4'h1}};
			gout_q   <= '0;
			pre_q    <= '0;
			mod_en_q <= 1'b0;
		end else begin
			sel_q    <= sel_d;
			gout_q   <= gout_d;
			pre_q    <= pre_d;
			mod_en_q <= mod_en;
		end
	end

	assign RDATA             = rdata_q;
	assign CHAN_INPUT_SELECT = sel_q;
	assign CHAN_GAIN         = gout_q;
	assign PRECHARGE_EN      = pre_q;
	assign POWER_MODE        = pwr_q;
	assign MOD_CLK_EN        = mod_en_q;
	assign SAMPLE_VALID      = out_q.valid;
	assign SAMPLE_CHAN       = out_q.chan;
	assign SAMPLE_DATA       = out_q.data;
endmodule

// ==== verif/acd_mod_model.sv ====
/* Stand-in for the eight modulators feeding the decimators.
   Assumes one master clock shared with the block under test. */
`timescale 1ns/1ps
module acd_mod_model (
	input  wire logic   clk,
	input  wire logic   rst_n,
	output logic [7:0]  mod_bits
);
	// Fixed densities give exact window sums, at the cost of no mid-scale cover.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_bits <= 8'h00;
		end else begin
			mod_bits <= 8'h0f;
		end
	end
endmodule

// ==== verif/acd_monitor.sv ====
/* Port checks for the channel configuration and decimation block.
   Assumes one clock domain and binding to acd_top. */
`timescale 1ns/1ps
module acd_monitor
	import acd_pkg::*;
#(
	parameter int REF_SETTLE = 10
) (
	input wire logic                CLK,
	input wire logic                RESET_N,
	input wire logic [ADDR_W-1:0]   ADDR,
	input wire logic [DATA_W-1:0]   WDATA,
	input wire logic                WR,
	input wire logic                RD,
	input wire logic [DATA_W-1:0]   RDATA,
	input wire logic [31:0]         CHAN_INPUT_SELECT,
	input wire logic [23:0]         CHAN_GAIN,
	input wire logic [7:0]          PRECHARGE_EN,
	input wire logic [1:0]          POWER_MODE,
	input wire logic                MOD_CLK_EN,
	input wire logic                SAMPLE_VALID,
	input wire logic [2:0]          SAMPLE_CHAN
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	int         since_q;
	int         since_d;
	logic [7:0] pre_exp;
	always_comb begin
		since_d = (since_q < 100000) ? since_q + 1 : since_q;
		for (int i = 0; i < NUM_CHAN; i++) begin
			pre_exp[i] = CHAN_GAIN[3*i +: 3] >= GAIN_BUF_MIN;
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			since_q <= 0;
		end else begin
			since_q <= since_d;
		end
	end
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data outside read cycle");
	mod_half_a: assert property ($past(RESET_N, 3) |-> MOD_CLK_EN != $past(MOD_CLK_EN))
		else $error("modulator enable not at half rate");
	precharge_gain_a: assert property ($stable(CHAN_GAIN) |-> PRECHARGE_EN == pre_exp)
		else $error("precharge does not follow gain");
	burst_len_a: assert property ($rose(SAMPLE_VALID) |-> SAMPLE_VALID[*8] ##1 !SAMPLE_VALID)
		else $error("sample burst length wrong");
	first_chan_a: assert property ($rose(SAMPLE_VALID) |-> SAMPLE_CHAN == 3'h0)
		else $error("burst start channel");
	chan_order_a: assert property (SAMPLE_VALID && $past(SAMPLE_VALID)
		|-> SAMPLE_CHAN == 3'($past(SAMPLE_CHAN) + 1)) else $error("channel order in burst");
	ref_hold_a: assert property (since_q < REF_SETTLE |-> !SAMPLE_VALID)
		else $error("data before reference ready");
	power_legal_a: assert property (POWER_MODE != 2'h3) else $error("illegal power mode");
	power_write_a: assert property (WR && ADDR == OFS_CLOCK && WDATA[1:0] != 2'h3
		|-> ##1 POWER_MODE == $past(WDATA[1:0])) else $error("power mode not written");
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_sel
		sel_onehot_a: assert property ($onehot(CHAN_INPUT_SELECT[4*g +: 4]))
			else $error("selector not one-hot");
	end
endmodule
bind acd_top acd_monitor #(.REF_SETTLE(REF_SETTLE)) u_mon (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CHAN_INPUT_SELECT(CHAN_INPUT_SELECT),
	.CHAN_GAIN(CHAN_GAIN), .PRECHARGE_EN(PRECHARGE_EN), .POWER_MODE(POWER_MODE), .MOD_CLK_EN(MOD_CLK_EN),
	.SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_CHAN(SAMPLE_CHAN));

// ==== verif/acd_top_tb.sv ====
/* Self-checking bench for the channel configuration and decimation block.
   Assumes the modulator model feeds fixed bit densities. */
`timescale 1ns/1ps
module acd_top_tb;
	import acd_pkg::*;
	// ****************************************
	// Stimulus and checks
	// ****************************************
	logic              CLK, RESET_N, wr, rd, mod_en, svalid;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata, rdata, rv, sel, sexp;
	logic [7:0]        mod_bits, pre_en;
	logic [23:0]       gain, sdata, gexp;
	logic [1:0]        power_mode_field;
	logic [2:0]        schan;
	int                errors, num_checks, cyc, t0, t1;
	bit                hung;
	acd_top #(.REF_SETTLE(10)) DUT (.CLK(CLK), .RESET_N(RESET_N), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .MOD_BITS(mod_bits), .CHAN_INPUT_SELECT(sel), .CHAN_GAIN(gain), .PRECHARGE_EN(pre_en),
		.POWER_MODE(power_mode_field), .MOD_CLK_EN(mod_en), .SAMPLE_VALID(svalid), .SAMPLE_CHAN(schan), .SAMPLE_DATA(sdata));
	acd_mod_model u_mod (.clk(CLK), .rst_n(RESET_N), .mod_bits(mod_bits));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge CLK);
		wr <= 1'b0;
		repeat (3) @(negedge CLK);
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge CLK);
		addr <= a;
		rd <= 1'b1;
		@(posedge CLK);
		rd <= 1'b0;
		@(negedge CLK);
		rv = rdata;
	endtask
	// Selectors cycle pins, ground, +test, -test; only channel 0 of the pins sees ones.
	task automatic wait_burst(output int t, input bit look);
		int          n;
		logic [31:0] dexp;
		n = 0;
		t = 0;
		if (!hung) begin
			@(negedge CLK);
			while (svalid !== 1'b1 && !hung) begin
				n++;
				if (n > 5000) begin
					errors++;
					hung = 1'b1;
				end
				@(negedge CLK);
			end
			t = cyc;
			for (int k = 0; k < 8 && !hung; k++) begin
				dexp = (k % 4 == 1) ? 32'h8000 : ((k == 0 || k % 4 == 2) ? 32'h10000 : 32'h0);
				if (look) begin
					chk(32'(schan), k);
					chk(32'(sdata), dexp);
				end
				@(negedge CLK);
			end
		end
	endtask
	initial begin
		CLK = 1'b0;
		// One master clock stands in for every power mode; only cycle counts are checked.
		forever #50 CLK = ~CLK;
	end
	always @(posedge CLK) cyc <= cyc + 1;
	initial begin
		RESET_N = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		cyc = 0;
		hung = 1'b0;
		repeat (12) @(posedge CLK);
		RESET_N <= 1'b1;
		@(negedge CLK);
		chk(rdata, 0);
		chk(sel, 32'h11111111);
		chk(32'(gain), 0);
		chk(32'(pre_en), 0);
		chk(32'(power_mode_field), 2);
		rd_reg(OFS_CLOCK);
		chk(rv, 32'h0e);
		wr_reg(4'h5, 32'hffffffff);
		rd_reg(4'h5);
		chk(rv, 0);
		for (int p = 0; p < 4; p++) begin
			wr_reg(OFS_CLOCK, 32'h0c | p);
			chk(32'(power_mode_field), p == 3 ? 2 : p);
		end
		wr_reg(OFS_GAIN, 32'h76543210);
		for (int i = 0; i < 8; i++) begin
			gexp[3*i +: 3] = 3'(i);
		end
		chk(32'(gain), 32'(gexp));
		chk(32'(pre_en), 32'hf8);
		rd_reg(OFS_GAIN);
		chk(rv, 32'h76543210);
		wr_reg(OFS_GAIN, 32'hf0000008);
		chk(32'(gain), 32'he00007);
		chk(32'(pre_en), 32'h81);
		for (int i = 0; i < 8; i++) begin
			wr_reg(4'(OFS_CHCFG0 + i), i % 4);
			sexp[4*i +: 4] = 4'h1 << (i % 4);
		end
		chk(sel, sexp);
		rd_reg(4'(OFS_CHCFG0 + 3));
		chk(rv, 3);
		rd_reg(OFS_STATUS);
		chk(32'(rv[0]), 1);
		for (int o = 0; o < 2; o++) begin
			wr_reg(OFS_CLOCK, (o << CLK_OSR_LSB) | 2);
			wait_burst(t0, 1'b0);
			wait_burst(t0, 1'b1);
			wait_burst(t1, 1'b1);
			chk(t1 - t0, 2 * (128 << o));
		end
		wrap_up();
	end
endmodule
